// file: hw/sfm_core.sv
/*
 * special-function register map of the 8-bit core: slot resolution through
 * the file select pointer, timer/counter, status, port data, setup bank,
 * accumulator and the control registers outside the data map.
 * assumes: the cpu issues at most one slot access per mclk, pins are
 * asynchronous, fuse strap is static while rst is high.
 */
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// [RQ1] every special register, mapped or not, is eight bits wide
// [RQ2] address zero stores nothing; it acts on the location the pointer names
// [RQ3] pointer sits at 04h, giving bank number or full address
// [RQ4] eight-bit timer at 01h, configured by settings register bits
// [RQ5] timekeeping mode counts instruction cycles or a chosen multiple
// [RQ6] event mode counts rising or falling edges of the timer pin
// [RQ7] timer may be read or overwritten at any moment
// [RQ8] wrap from FFh to 00h requests interrupt when enabled
// [RQ9] address 02h shows only low byte of the program counter
// [RQ10] status register with carry, zero and page bits at 03h
// [RQ11] port data at 05h-09h: writes drive outputs, reads return pins
// [RQ12] missing ports C, D, E leave plain storage at 07h-09h
// [RQ13] setup bank unmapped, written by config instruction, chosen by select register
// [RQ14] by default accumulator is reached only by naming it directly
// [RQ15] accumulator maps at 01h only if fuse bit and select bit are 0
// [RQ16] while accumulator is mapped, timer is unreachable at 01h
// [RQ17] watchdog and sleep flags ignore software writes; other bits writable
// [RQ18] bank-relative address joins pointer upper nibble with field lower nibble
module sfm_core #(
	parameter logic [4:0] PORT_PRESENT = 5'h1f
) (
	input  wire logic                  mclk,
	input  wire logic                  rst,
	input  wire logic                  req_valid,
	input  wire sfm_pkg::sfm_req_t     req,
	output logic                       rsp_valid,
	output logic [7:0]                 rsp_rdata,
	input  wire sfm_pkg::sfm_ctl_t     ctl,
	input  wire logic                  acc_write,
	input  wire logic [7:0]            acc_wdata,
	output logic [7:0]                 accumulator,
	output logic [7:0]                 device_settings,
	output logic [7:0]                 port_control_select,
	output logic [7:0]                 status_flags,
	input  wire logic                  alu_flags_we,
	input  wire logic [2:0]            alu_flags,
	input  wire logic                  wdog_expired,
	input  wire logic                  sleep_exec,
	input  wire logic                  wdog_clear,
	input  wire logic [7:0]            code_pointer_in,
	output logic                       code_load_valid,
	output logic [7:0]                 code_load_data,
	input  wire logic                  fuse_map_enable,
	input  wire logic                  timer_pin,
	output logic                       timer_irq,
	input  wire logic [4:0][7:0]       port_in,
	output logic [4:0][7:0]            port_out,
	output logic [4:0][7:0]            port_oe
);

	// ----------------------------------------------------------------
	// storage
	// ----------------------------------------------------------------
	logic [7:0]      file_select_pointer;
	logic [7:0]      timer_count;
	logic [7:0]      prescale_count;
	logic [7:0]      gp_mem [0:255];
	logic [4:0][7:0] port_data;
	logic            fuse_q;
	logic [40:0]     pin_s1;
	logic [40:0]     pin_s2;
	logic [40:0]     pin_s3;
	logic [40:0]     pin_f;
	logic            tpin_prev;

	// ----------------------------------------------------------------
	// input synchronisers
	// ----------------------------------------------------------------
	logic [40:0] pin_raw;
	assign pin_raw = {timer_pin, port_in};

	// three stages; filtered level moves only when stages two and three agree
	genvar gi;
	generate
		for (gi = 0; gi < 41; gi++) begin : g_sync
			always_ff @(posedge mclk) begin
				if (rst) begin
					pin_s1[gi] <= 1'b0;
					pin_s2[gi] <= 1'b0;
					pin_s3[gi] <= 1'b0;
					pin_f[gi]  <= 1'b0;
				end else begin
					pin_s1[gi] <= pin_raw[gi];
					pin_s2[gi] <= pin_s1[gi];
					pin_s3[gi] <= pin_s2[gi];
					if (pin_s2[gi] == pin_s3[gi]) begin
						pin_f[gi] <= pin_s3[gi];
					end
				end
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// address resolution
	// ----------------------------------------------------------------
	logic [7:0] eff_addr;
	logic       acc_mapped;
	logic       wr;
	logic       rd;

	// [RQ2] pointed slot redirect
	// [RQ18] bank-relative join
	always_comb begin
		if (req.field == 5'h00) begin
			eff_addr = file_select_pointer;
		end else if (!req.field[4]) begin
			eff_addr = {3'h0, req.field};
		end else begin
			eff_addr = {file_select_pointer[7:4], req.field[3:0]};
		end
	end

	// [RQ15] accumulator map condition
	assign acc_mapped = !fuse_q && !device_settings[sfm_pkg::DS_ACC_SEL];
	// [RQ2] address zero holds nothing, so writes there are dropped
	assign wr = req_valid && req.write && (eff_addr != sfm_pkg::ADDR_SLOT);
	assign rd = req_valid && !req.write;

	// fuse strap caught while reset is held
	always_ff @(posedge mclk) begin
		if (rst) begin
			fuse_q <= fuse_map_enable;
		end
	end

	// ----------------------------------------------------------------
	// read path
	// ----------------------------------------------------------------
	logic [7:0] next_rdata;
	logic [3:0] port_idx;
	assign port_idx = eff_addr[3:0] - sfm_pkg::ADDR_PORT_A[3:0];

	// [RQ11] reads return pin levels
	// [RQ12] absent ports read back storage
	always_comb begin
		next_rdata = 8'h00;
		if (eff_addr == sfm_pkg::ADDR_TIMER) begin
			next_rdata = acc_mapped ? accumulator : timer_count;
		end else if (eff_addr == sfm_pkg::ADDR_CODE_LOW) begin
			next_rdata = code_pointer_in;
		end else if (eff_addr == sfm_pkg::ADDR_STATUS) begin
			next_rdata = status_flags;
		end else if (eff_addr == sfm_pkg::ADDR_FSP) begin
			next_rdata = file_select_pointer;
		end else if (eff_addr >= sfm_pkg::ADDR_PORT_A && eff_addr <= sfm_pkg::ADDR_PORT_E) begin
			next_rdata = PORT_PRESENT[port_idx[2:0]] ? pin_f[port_idx[2:0]*8 +: 8]
				: port_data[port_idx[2:0]];
		end else if (eff_addr != sfm_pkg::ADDR_SLOT) begin
			next_rdata = gp_mem[eff_addr];
		end
	end

	// one-cycle answer for every slot request
	always_ff @(posedge mclk) begin
		if (rst) begin
			rsp_valid <= 1'b0;
			rsp_rdata <= 8'h00;
		end else begin
			rsp_valid <= req_valid;
			if (rd) begin
				rsp_rdata <= next_rdata;
			end
		end
	end

	// ----------------------------------------------------------------
	// general storage above the special registers
	// ----------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (wr && eff_addr > sfm_pkg::ADDR_PORT_E) begin
			gp_mem[eff_addr] <= req.wdata;
		end
	end

	// ----------------------------------------------------------------
	// pointer, accumulator, code pointer low
	// ----------------------------------------------------------------
	// [RQ3] pointer at 04h
	always_ff @(posedge mclk) begin
		if (rst) begin
			file_select_pointer <= 8'h00;
		end else if (wr && eff_addr == sfm_pkg::ADDR_FSP) begin
			file_select_pointer <= req.wdata;
		end
	end

	// [RQ14] direct accumulator port
	// [RQ15] slot write reaches it only while mapped
	always_ff @(posedge mclk) begin
		if (rst) begin
			accumulator <= 8'h00;
		end else if (wr && eff_addr == sfm_pkg::ADDR_TIMER && acc_mapped) begin
			accumulator <= req.wdata;
		end else if (acc_write) begin
			accumulator <= acc_wdata;
		end
	end

	// [RQ9] low byte load toward the cpu
	always_ff @(posedge mclk) begin
		if (rst) begin
			code_load_valid <= 1'b0;
			code_load_data  <= 8'h00;
		end else begin
			code_load_valid <= wr && eff_addr == sfm_pkg::ADDR_CODE_LOW;
			if (wr && eff_addr == sfm_pkg::ADDR_CODE_LOW) begin
				code_load_data <= req.wdata;
			end
		end
	end

	// ----------------------------------------------------------------
	// status
	// ----------------------------------------------------------------
	// [RQ10] status at 03h, alu updates win over software
	// [RQ17] watchdog and sleep bits only follow events
	always_ff @(posedge mclk) begin
		if (rst) begin
			status_flags <= sfm_pkg::ST_RESET;
		end else begin
			if (wr && eff_addr == sfm_pkg::ADDR_STATUS) begin
				status_flags <= (req.wdata & sfm_pkg::ST_SW_MASK)
					| (status_flags & ~sfm_pkg::ST_SW_MASK);
			end
			if (alu_flags_we) begin
				status_flags[sfm_pkg::ST_ZERO:sfm_pkg::ST_CARRY] <= alu_flags;
			end
			if (wdog_expired) begin
				status_flags[sfm_pkg::ST_WDOG] <= 1'b0;
			end else if (wdog_clear || sleep_exec) begin
				status_flags[sfm_pkg::ST_WDOG] <= 1'b1;
			end
			if (sleep_exec) begin
				status_flags[sfm_pkg::ST_SLEEP] <= 1'b0;
			end else if (wdog_clear) begin
				status_flags[sfm_pkg::ST_SLEEP] <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// control registers outside the map
	// ----------------------------------------------------------------
	// [RQ1] eight-bit control registers
	always_ff @(posedge mclk) begin
		if (rst) begin
			device_settings     <= sfm_pkg::DS_RESET;
			port_control_select <= sfm_pkg::SEL_RESET;
		end else begin
			if (ctl.write_settings) begin
				device_settings <= ctl.wdata;
			end
			if (ctl.write_select) begin
				port_control_select <= ctl.wdata;
			end
		end
	end

	// ----------------------------------------------------------------
	// ports and setup bank
	// ----------------------------------------------------------------
	// [RQ11] port data write
	// [RQ12] absent ports keep plain storage
	// [RQ13] setup write steered by select register
	generate
		for (gi = 0; gi < 5; gi++) begin : g_port
			always_ff @(posedge mclk) begin
				if (rst) begin
					port_data[gi] <= 8'h00;
				end else if (wr && eff_addr == sfm_pkg::ADDR_PORT_A + 8'(gi)) begin
					port_data[gi] <= req.wdata;
				end
			end
			always_ff @(posedge mclk) begin
				if (rst) begin
					port_out[gi] <= 8'h00;
					port_oe[gi]  <= 8'h00;
				end else begin
					port_out[gi] <= port_data[gi];
					if (PORT_PRESENT[gi] && ctl.write_setup && ctl.setup_port == 3'(gi)
						&& port_control_select == sfm_pkg::SEL_DIR_CODE) begin
						port_oe[gi] <= ~ctl.wdata;
					end
				end
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// timer/counter
	// ----------------------------------------------------------------
	logic       tpin_f;
	logic       ext_edge;
	logic       tick_src;
	logic [7:0] ps_mask;
	logic       timer_inc;
	logic       timer_wr;

	assign tpin_f = pin_f[40];
	// [RQ6] rising or falling pin edge
	assign ext_edge = device_settings[sfm_pkg::DS_FALL_EDGE] ? (tpin_prev && !tpin_f)
		: (!tpin_prev && tpin_f);
	// [RQ5] each instruction cycle or pin event
	assign tick_src = device_settings[sfm_pkg::DS_EXT_SRC] ? ext_edge : 1'b1;
	assign ps_mask = ~(8'hff << ({1'b0, device_settings[2:0]} + 4'h1));
	assign timer_inc = device_settings[sfm_pkg::DS_PRE_BYPASS] ? tick_src
		: (tick_src && (prescale_count & ps_mask) == ps_mask);
	// [RQ16] timer hidden while accumulator mapped
	assign timer_wr = wr && eff_addr == sfm_pkg::ADDR_TIMER && !acc_mapped;

	always_ff @(posedge mclk) begin
		if (rst) begin
			tpin_prev <= 1'b0;
		end else begin
			tpin_prev <= tpin_f;
		end
	end

	// [RQ5] prescaler divides by two to the ratio plus one
	always_ff @(posedge mclk) begin
		if (rst || timer_wr) begin
			prescale_count <= 8'h00;
		end else if (tick_src && !device_settings[sfm_pkg::DS_PRE_BYPASS]) begin
			prescale_count <= prescale_count + 8'h01;
		end
	end

	// [RQ4] timer at 01h
	// [RQ7] write any time, write beats count
	always_ff @(posedge mclk) begin
		if (rst) begin
			timer_count <= 8'h00;
		end else if (timer_wr) begin
			timer_count <= req.wdata;
		end else if (timer_inc) begin
			timer_count <= timer_count + 8'h01;
		end
	end

	// [RQ8] rollover request when enabled
	always_ff @(posedge mclk) begin
		if (rst) begin
			timer_irq <= 1'b0;
		end else begin
			timer_irq <= !timer_wr && timer_inc && timer_count == 8'hff
				&& device_settings[sfm_pkg::DS_ROLL_IE];
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	rsp_timing_a: assert property (@(posedge mclk) disable iff (rst) // [RQ2]
		(rd && eff_addr == sfm_pkg::ADDR_SLOT) |=> rsp_valid && rsp_rdata == 8'h00)
		else $error("pointed slot at zero not answered with zero");

	wrap_irq_a: assert property (@(posedge mclk) disable iff (rst) // [RQ8]
		(timer_inc && !timer_wr && timer_count == 8'hff
			&& device_settings[sfm_pkg::DS_ROLL_IE]) |=> timer_irq && timer_count == 8'h00)
		else $error("rollover did not raise request");

	irq_cause_a: assert property (@(posedge mclk) disable iff (rst) // [RQ8]
		timer_irq |-> $past(timer_count) == 8'hff && timer_count == 8'h00)
		else $error("request without rollover");

	status_ro_a: assert property (@(posedge mclk) disable iff (rst) // [RQ17]
		(wr && eff_addr == sfm_pkg::ADDR_STATUS && !wdog_expired && !sleep_exec
			&& !wdog_clear) |=> $stable(status_flags[4:3]))
		else $error("protected status bits changed by write");

	acc_map_a: assert property (@(posedge mclk) disable iff (rst) // [RQ15]
		(wr && eff_addr == sfm_pkg::ADDR_TIMER && acc_mapped)
			|=> accumulator == $past(req.wdata))
		else $error("mapped accumulator not written");

	timer_hide_a: assert property (@(posedge mclk) disable iff (rst) // [RQ16]
		(acc_mapped && !timer_inc) |=> timer_count == $past(timer_count))
		else $error("hidden timer changed");

	timer_write_a: assert property (@(posedge mclk) disable iff (rst) // [RQ7]
		timer_wr |=> timer_count == $past(req.wdata))
		else $error("timer write lost");

	pointer_write_a: assert property (@(posedge mclk) disable iff (rst) // [RQ3]
		(wr && eff_addr == sfm_pkg::ADDR_FSP) |=> file_select_pointer == $past(req.wdata))
		else $error("pointer write lost");

	port_drive_a: assert property (@(posedge mclk) disable iff (rst) // [RQ11]
		(wr && eff_addr == sfm_pkg::ADDR_PORT_A) |=> ##1 port_out[0] == $past(req.wdata, 2))
		else $error("port a output not driven");

	code_load_a: assert property (@(posedge mclk) disable iff (rst) // [RQ9]
		(wr && eff_addr == sfm_pkg::ADDR_CODE_LOW)
			|=> code_load_valid && code_load_data == $past(req.wdata))
		else $error("code pointer load missing");

endmodule

`default_nettype wire

// file: hw/sfm_pkg.sv
/*
 * shared constants and types for the special-function register map:
 * register addresses, status and settings field positions, reset values.
 * assumes: an 8-bit core where one mclk edge is one instruction cycle.
 */
package sfm_pkg;

	// ----------------------------------------------------------------
	// data widths and addresses
	// ----------------------------------------------------------------
	localparam int unsigned DW               = 8;
	localparam int unsigned NPORT            = 5;
	localparam logic [7:0]  ADDR_SLOT        = 8'h00;
	localparam logic [7:0]  ADDR_TIMER       = 8'h01;
	localparam logic [7:0]  ADDR_CODE_LOW    = 8'h02;
	localparam logic [7:0]  ADDR_STATUS      = 8'h03;
	localparam logic [7:0]  ADDR_FSP         = 8'h04;
	localparam logic [7:0]  ADDR_PORT_A      = 8'h05;
	localparam logic [7:0]  ADDR_PORT_E      = 8'h09;

	// ----------------------------------------------------------------
	// status_flags fields
	// ----------------------------------------------------------------
	localparam int unsigned ST_PAGE_LSB      = 5;
	localparam int unsigned ST_WDOG          = 4;
	localparam int unsigned ST_SLEEP         = 3;
	localparam int unsigned ST_ZERO          = 2;
	localparam int unsigned ST_DCARRY        = 1;
	localparam int unsigned ST_CARRY         = 0;
	localparam logic [7:0]  ST_SW_MASK       = 8'he7;
	localparam logic [7:0]  ST_RESET         = 8'h18;

	// ----------------------------------------------------------------
	// device_settings and port_control_select fields
	// ----------------------------------------------------------------
	localparam int unsigned DS_ACC_SEL       = 7;
	localparam int unsigned DS_ROLL_IE       = 6;
	localparam int unsigned DS_EXT_SRC       = 5;
	localparam int unsigned DS_FALL_EDGE     = 4;
	localparam int unsigned DS_PRE_BYPASS    = 3;
	localparam int unsigned DS_RATIO_LSB     = 0;
	localparam logic [7:0]  DS_RESET         = 8'hff;
	localparam logic [7:0]  SEL_RESET        = 8'h0f;
	localparam logic [7:0]  SEL_DIR_CODE     = 8'h0f;

	// ----------------------------------------------------------------
	// request carrier
	// ----------------------------------------------------------------
	typedef struct packed {
		logic       write;
		logic [4:0] field;
		logic [7:0] wdata;
	} sfm_req_t;

	typedef struct packed {
		logic       write_settings;
		logic       write_select;
		logic       write_setup;
		logic [2:0] setup_port;
		logic [7:0] wdata;
	} sfm_ctl_t;

endpackage

// file: verification/sfm_tb.sv
/*
 * self-checking bench for sfm_core: slot reads and writes, control strobes,
 * timer, accumulator mapping, status protection and port data.
 * assumes: sfm_pkg compiled first; inputs change on the falling edge of mclk.
 */
`timescale 1ns/1ps
`default_nettype none

module tb;
	logic                mclk;
	logic                rst;
	logic                req_valid;
	sfm_pkg::sfm_req_t   req;
	logic                rsp_valid;
	logic [7:0]          rsp_rdata;
	sfm_pkg::sfm_ctl_t   ctl;
	logic                acc_write;
	logic [7:0]          acc_wdata;
	logic [7:0]          accumulator;
	logic [7:0]          device_settings;
	logic [7:0]          port_control_select;
	logic [7:0]          status_flags;
	logic                wdog_expired;
	logic                wdog_clear;
	logic                sleep_exec;
	logic                fuse_map_enable;
	logic [7:0]          rsp_rdata_gp;
	logic [7:0]          code_pointer_in;
	logic                code_load_valid;
	logic [7:0]          code_load_data;
	logic                timer_pin;
	logic                timer_irq;
	logic [4:0][7:0]     port_in;
	logic [4:0][7:0]     port_out;
	logic [4:0][7:0]     port_oe;
	int                  n_errors;
	int                  n_compared;
	logic [7:0]          r1;
	logic [7:0]          r2;
	logic                seen;

	sfm_core DUT (
		.mclk(mclk), .rst(rst), .req_valid(req_valid), .req(req),
		.rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .ctl(ctl),
		.acc_write(acc_write), .acc_wdata(acc_wdata), .accumulator(accumulator),
		.device_settings(device_settings), .port_control_select(port_control_select),
		.status_flags(status_flags), .alu_flags_we(1'b0), .alu_flags(3'h0),
		.wdog_expired(wdog_expired), .sleep_exec(sleep_exec), .wdog_clear(wdog_clear),
		.code_pointer_in(code_pointer_in), .code_load_valid(code_load_valid),
		.code_load_data(code_load_data), .fuse_map_enable(fuse_map_enable),
		.timer_pin(timer_pin), .timer_irq(timer_irq), .port_in(port_in),
		.port_out(port_out), .port_oe(port_oe)
	);

	// second map with ports c, d and e absent, fed the same stimulus
	sfm_core #(
		.PORT_PRESENT(5'h03)
	) DUT_gp (
		.mclk(mclk), .rst(rst), .req_valid(req_valid), .req(req),
		.rsp_valid(), .rsp_rdata(rsp_rdata_gp), .ctl(ctl),
		.acc_write(acc_write), .acc_wdata(acc_wdata), .accumulator(),
		.device_settings(), .port_control_select(),
		.status_flags(), .alu_flags_we(1'b0), .alu_flags(3'h0),
		.wdog_expired(wdog_expired), .sleep_exec(sleep_exec), .wdog_clear(wdog_clear),
		.code_pointer_in(code_pointer_in), .code_load_valid(),
		.code_load_data(), .fuse_map_enable(fuse_map_enable),
		.timer_pin(timer_pin), .timer_irq(), .port_in(port_in),
		.port_out(), .port_oe()
	);

	// ----------------------------------------------------------------
	// clock, verdict and watchdog
	// ----------------------------------------------------------------
	initial mclk = 1'b0;
	always #20 mclk = ~mclk;

	task automatic give_verdict();
		$display("compared %0d, mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// cut a hang short well beyond the expected run length
	initial begin
		repeat (5000) @(posedge mclk);
		n_errors++;
		give_verdict();
	end

	// ----------------------------------------------------------------
	// access tasks
	// ----------------------------------------------------------------
	task automatic check(input logic [7:0] got, input logic [7:0] exp, input string msg);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %0t %s: seen %h expected %h", $time, msg, got, exp);
		end
	endtask

	// one slot access; answer is sampled the cycle after the request edge
	task automatic slot(input logic wr, input logic [4:0] fld, input logic [7:0] wd,
			output logic [7:0] rd);
		@(negedge mclk);
		req_valid = 1'b1;
		req.write = wr;
		req.field = fld;
		req.wdata = wd;
		@(negedge mclk);
		req_valid = 1'b0;
		rd = rsp_rdata;
		check({7'h0, rsp_valid}, 8'h01, "slot answer strobe");
	endtask

	task automatic wr(input logic [4:0] fld, input logic [7:0] wd);
		logic [7:0] dummy;
		slot(1'b1, fld, wd, dummy);
	endtask

	task automatic rd_chk(input logic [4:0] fld, input logic [7:0] exp, input string msg);
		logic [7:0] v;
		slot(1'b0, fld, 8'h00, v);
		check(v, exp, msg);
	endtask

	// kind = {settings, select, setup}
	task automatic ctl_op(input logic [2:0] kind, input logic [2:0] prt, input logic [7:0] wd);
		@(negedge mclk);
		ctl = {kind, prt, wd};
		@(negedge mclk);
		ctl = '0;
	endtask

	task automatic pin_pulses();
		repeat (3) begin
			timer_pin = 1'b1;
			repeat (4) @(negedge mclk);
			timer_pin = 1'b0;
			repeat (4) @(negedge mclk);
		end
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		n_errors = 0;
		n_compared = 0;
		rst = 1'b1;
		req_valid = 1'b0;
		req = '0;
		ctl = '0;
		acc_write = 1'b0;
		acc_wdata = 8'h00;
		wdog_expired = 1'b0;
		wdog_clear = 1'b0;
		sleep_exec = 1'b0;
		fuse_map_enable = 1'b0;
		code_pointer_in = 8'h42;
		timer_pin = 1'b0;
		for (int i = 0; i < 5; i++) port_in[i] = 8'ha0 + 8'(i);
		repeat (6) @(negedge mclk);
		rst = 1'b0;
		check(device_settings, sfm_pkg::DS_RESET, "settings reset");
		check(port_control_select, sfm_pkg::SEL_RESET, "select reset");
		check(accumulator, 8'h00, "accumulator reset");
		rd_chk(5'h03, sfm_pkg::ST_RESET, "status reset value");
		wr(5'h03, 8'h00);
		rd_chk(5'h03, 8'h18, "status write zero");
		wr(5'h03, 8'hff);
		check(status_flags, 8'hff, "status write ones");
		@(negedge mclk) wdog_expired = 1'b1;
		@(negedge mclk) wdog_expired = 1'b0;
		rd_chk(5'h03, 8'hef, "watchdog expiry clears bit");
		@(negedge mclk) wdog_clear = 1'b1;
		@(negedge mclk) wdog_clear = 1'b0;
		check(status_flags, 8'hff, "watchdog clear");
		@(negedge mclk) sleep_exec = 1'b1;
		@(negedge mclk) sleep_exec = 1'b0;
		check(status_flags, 8'hf7, "sleep clears sleep bit");
		wr(5'h04, 8'h00);
		wr(5'h00, 8'h5e);
		rd_chk(5'h00, 8'h00, "pointer at zero stores nothing");
		wr(5'h04, 8'h25);
		rd_chk(5'h04, 8'h25, "pointer readback");
		wr(5'h00, 8'h66);
		rd_chk(5'h00, 8'h66, "indirect readback");
		rd_chk(5'h15, 8'h66, "bank relative readback");
		rd_chk(5'h02, 8'h42, "code pointer low");
		wr(5'h02, 8'h9c);
		check({7'h0, code_load_valid}, 8'h01, "code load strobe");
		check(code_load_data, 8'h9c, "code load data");
		// port data out and pins in
		for (int i = 0; i < 5; i++) begin
			wr(5'h05 + 5'(i), 8'h30 + 8'(i));
			@(negedge mclk);
			check(port_out[i], 8'h30 + 8'(i), "port output");
			rd_chk(5'h05 + 5'(i), 8'ha0 + 8'(i), "port pins");
			check(rsp_rdata_gp, (i < 2) ? 8'ha0 + 8'(i) : 8'h30 + 8'(i), "absent port");
		end
		// setup bank reached only through the select code
		ctl_op(3'b001, 3'd1, 8'hf0);
		check(port_oe[1], 8'h0f, "setup write direction");
		ctl_op(3'b010, 3'd0, 8'h00);
		check(port_control_select, 8'h00, "select write");
		ctl_op(3'b001, 3'd1, 8'h00);
		check(port_oe[1], 8'h0f, "setup ignored");
		ctl_op(3'b100, 3'd0, 8'hc8);
		slot(1'b0, 5'h01, 8'h00, r1);
		repeat (6) @(negedge mclk);
		slot(1'b0, 5'h01, 8'h00, r2);
		check(r2 - r1, 8'h08, "count every cycle");
		for (int en = 1; en >= 0; en--) begin
			ctl_op(3'b100, 3'd0, en ? 8'hc8 : 8'h88);
			wr(5'h01, 8'hfd);
			seen = 1'b0;
			repeat (20) @(negedge mclk) if (timer_irq === 1'b1) seen = 1'b1;
			check({7'h0, seen}, 8'(en), "rollover request");
		end
		for (int r = 0; r < 3; r++) begin
			ctl_op(3'b100, 3'd0, 8'h80 | 8'(r));
			slot(1'b0, 5'h01, 8'h00, r1);
			repeat (30) @(negedge mclk);
			slot(1'b0, 5'h01, 8'h00, r2);
			check(r2 - r1, 8'h10 >> r, "prescaled count");
		end
		for (int e = 0; e < 2; e++) begin
			ctl_op(3'b100, 3'd0, 8'ha8 | 8'(e << 4));
			wr(5'h01, 8'h00);
			pin_pulses();
			repeat (8) @(negedge mclk);
			rd_chk(5'h01, 8'h03, "pin edge count");
		end
		wr(5'h01, 8'h11);
		@(negedge mclk) begin
			acc_write = 1'b1;
			acc_wdata = 8'h5a;
		end
		@(negedge mclk) acc_write = 1'b0;
		rd_chk(5'h01, 8'h11, "timer visible when unmapped");
		ctl_op(3'b100, 3'd0, 8'h28);
		rd_chk(5'h01, 8'h5a, "accumulator mapped");
		wr(5'h01, 8'h77);
		check(accumulator, 8'h77, "mapped write");
		ctl_op(3'b100, 3'd0, 8'ha8);
		rd_chk(5'h01, 8'h11, "timer untouched");
		// fuse strap high keeps the timer at 01h after a mid-run reset
		@(negedge mclk) begin
			rst = 1'b1;
			fuse_map_enable = 1'b1;
		end
		repeat (4) @(negedge mclk);
		rst = 1'b0;
		check(accumulator, 8'h00, "accumulator after second reset");
		ctl_op(3'b100, 3'd0, 8'h28);
		wr(5'h01, 8'h33);
		check(accumulator, 8'h00, "fuse blocks mapped write");
		rd_chk(5'h01, 8'h33, "timer kept at 01h");
		give_verdict();
	end
endmodule

`default_nettype wire
